// ===== core/dsw_switch.v
// Added by the designer: register access over Wishbone and the register addresses.
`include "dsw_map.vh"
// Notes on behaviour
// - Table entry keyed by origin CID, holds destination CID
// - Entry stores destination aggregation ability
// - Matched uplink gets downlink SID/LNID/LCID/NAD
// - Directly switched frame leaves as downlink
// - Switch directly serves nodes below itself
// - Aggregation optional, enabled by control bit
// - Never aggregate across non-capable path
// - CAP_PA reported and granted at registration
// - Data packets carry NAD from registration
// - Last switch obeys NAD toward destination
// - Record capability, skip non-capable next switch
// - Aggregate size capped by robust burst
// - Own-SID PRO_ACK records NAD capability
// - Other-SID PRO_ACK inherits parent's capability
// - Uplink aggregation needs granted CAP_PA
// - Last level aggregates only when NAD zero
// - Otherwise permission from switching table
// - Direct CON open adds table entry
// - Direct CON close removes table entry
module dsw_switch #(
  parameter SID_W = 8,
  parameter LNID_W = 14,
  parameter LCID_W = 8,
  parameter DEPTH = 8,
  parameter LEN_W = 16
) (
  input wire i_clk, // 25 MHz clock
  input wire i_arst_n, // Async reset, active low
  input wire [7:0] i_wb_adr, // Wishbone address
  input wire [31:0] i_wb_dat, // Wishbone write data
  input wire [3:0] i_wb_sel, // Wishbone byte selects
  input wire i_wb_we, // Wishbone write enable
  input wire i_wb_cyc, // Wishbone cycle
  input wire i_wb_stb, // Wishbone strobe
  output reg [31:0] o_wb_dat, // Wishbone read data
  output reg o_wb_ack, // Wishbone acknowledge
  input wire i_pkt_valid, // Switchable packet header valid
  input wire i_pkt_dir, // HDR.DO
  input wire [SID_W-1:0] i_pkt_sid, // PKT.SID
  input wire [LNID_W-1:0] i_pkt_lnid, // PKT.LNID
  input wire [LCID_W-1:0] i_pkt_lcid, // PKT.LCID
  input wire i_pkt_nad, // PKT.NAD
  input wire [LEN_W-1:0] i_pkt_len, // Packet length in bytes
  input wire i_con_valid, // CON control packet observed
  input wire i_con_type, // CON.TYPE
  input wire i_con_n, // CON.N
  input wire i_con_d, // CON.D
  input wire [SID_W-1:0] i_con_dssid, // CON.DSSID
  input wire [LCID_W-1:0] i_con_lcid, // CON.LCID
  input wire [SID_W-1:0] i_con_dcsid, // CON.DCSID
  input wire [LNID_W-1:0] i_con_dclnid, // CON.DCLNID
  input wire [LCID_W-1:0] i_con_dclcid, // CON.DCLCID
  input wire i_con_dcnad, // CON.DCNAD
  input wire i_pro_valid, // PRO_ACK observed
  input wire [SID_W-1:0] i_pro_new_sid, // SID of promoted Switch
  input wire i_reg_rsp_valid, // Own REG_RSP received
  input wire i_reg_cap_pa, // REG.CAP_PA of own REG_RSP
  output reg o_out_valid, // Forwarded header valid
  output reg o_out_dir, // HDR.DO out
  output reg [SID_W-1:0] o_out_sid, // PKT.SID out
  output reg [LNID_W-1:0] o_out_lnid, // PKT.LNID out
  output reg [LCID_W-1:0] o_out_lcid, // PKT.LCID out
  output reg o_out_nad, // PKT.NAD out
  output reg o_out_direct, // Packet was turned around locally
  output reg o_out_agg_ok, // Packet may be aggregated
  output reg o_cap_pa // Own CAP_PA to report in REG_REQ
);
  localparam CID_W = SID_W + LNID_W + LCID_W;
  localparam ST_IDLE = 1'b0;
  localparam ST_ACK = 1'b1;

  reg [31:0] ctrl;
  reg [LEN_W-1:0] max_size;
  reg up_cap;
  reg [15:0] direct_cnt;
  reg bus_st;
  wire [SID_W-1:0] own_sid;
  wire sw_en;
  wire agg_en;
  wire con_direct;
  wire tbl_add;
  wire tbl_del;
  wire tbl_hit;
  wire [CID_W-1:0] tbl_dn;
  wire tbl_nad;
  wire [7:0] tbl_count;
  wire look_cap;
  wire is_up_hit;
  wire next_agg;
  wire fits;

  function [31:0] merge_bytes;
    input [31:0] old;
    input [31:0] wdat;
    input [3:0] sel;
    integer b;
    begin
      merge_bytes = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          merge_bytes[b*8 +: 8] = wdat[b*8 +: 8];
        end
      end
    end
  endfunction

  assign own_sid = ctrl[`DSW_CTRL_SID_LSB +: SID_W];
  assign sw_en = ctrl[`DSW_CTRL_EN_BIT];
  assign agg_en = ctrl[`DSW_CTRL_AGG_BIT];

  // Direct information addressed to this Switch only
  assign con_direct = i_con_valid && sw_en && i_con_type == `DSW_CON_TYPE_DIRECT
    && i_pkt_dir == `DSW_DIR_DOWN && i_con_d && i_con_dssid == own_sid;
  assign tbl_add = con_direct && i_con_n == `DSW_CON_N_OPEN;
  assign tbl_del = con_direct && i_con_n == `DSW_CON_N_CLOSE;

  dsw_direct_table #(
    .DEPTH(DEPTH),
    .CID_W(CID_W)
  ) u_direct (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_add(tbl_add),
    .i_del(tbl_del),
    .i_wr_up({i_pkt_sid, i_pkt_lnid, i_con_lcid}),
    .i_wr_dn({i_con_dcsid, i_con_dclnid, i_con_dclcid}),
    .i_wr_nad(i_con_dcnad),
    .i_look_up({i_pkt_sid, i_pkt_lnid, i_pkt_lcid}),
    .o_hit(tbl_hit),
    .o_dn(tbl_dn),
    .o_nad(tbl_nad),
    .o_count(tbl_count)
  );

  dsw_cap_table #(
    .SID_W(SID_W)
  ) u_cap (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_pro_valid(i_pro_valid && sw_en),
    .i_pro_sid(i_pkt_sid),
    .i_pro_new_sid(i_pro_new_sid),
    .i_pro_nad(i_pkt_nad),
    .i_own_sid(own_sid),
    .i_look_sid(i_pkt_sid),
    .o_look_cap(look_cap)
  );

  // Uplink path capability from own registration response; own CAP_PA follows the aggregation enable bit
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      up_cap <= 1'b0;
      o_cap_pa <= 1'b0;
    end else begin
      o_cap_pa <= agg_en;
      if (i_reg_rsp_valid) begin
        up_cap <= i_reg_cap_pa;
      end
    end
  end

  assign is_up_hit = i_pkt_dir == `DSW_DIR_UP && tbl_hit;
  // Burst limit keeps one aggregate inside the most robust PHY burst
  assign fits = i_pkt_len <= max_size;

  // Aggregation permission; direct hits and last level follow destination NAD, others the next hop's capability
  assign next_agg = !agg_en || !fits ? 1'b0 :
    is_up_hit ? !tbl_nad :
    i_pkt_dir == `DSW_DIR_UP ? up_cap :
    i_pkt_sid == own_sid ? !i_pkt_nad :
    look_cap;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_out_valid <= 1'b0;
      o_out_dir <= 1'b0;
      o_out_sid <= {SID_W{1'b0}};
      o_out_lnid <= {LNID_W{1'b0}};
      o_out_lcid <= {LCID_W{1'b0}};
      o_out_nad <= 1'b0;
      o_out_direct <= 1'b0;
      o_out_agg_ok <= 1'b0;
      direct_cnt <= 16'h0000;
    end else begin
      o_out_valid <= i_pkt_valid && sw_en;
      o_out_agg_ok <= i_pkt_valid && sw_en && next_agg;
      if (i_pkt_valid && sw_en && is_up_hit) begin
        {o_out_sid, o_out_lnid, o_out_lcid} <= tbl_dn;
        o_out_nad <= tbl_nad;
        o_out_dir <= `DSW_DIR_DOWN;
        o_out_direct <= 1'b1;
        direct_cnt <= direct_cnt + 16'h0001;
      end else if (i_pkt_valid) begin
        o_out_sid <= i_pkt_sid;
        o_out_lnid <= i_pkt_lnid;
        o_out_lcid <= i_pkt_lcid;
        o_out_nad <= i_pkt_nad;
        o_out_dir <= i_pkt_dir;
        o_out_direct <= 1'b0;
      end
    end
  end

  // Wishbone classic slave, two wait states then ack
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bus_st <= ST_IDLE;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
      ctrl <= `DSW_CTRL_RST;
      max_size <= `DSW_SIZE_RST;
    end else begin
      case (bus_st)
        ST_IDLE: begin
          o_wb_ack <= 1'b0;
          // A request still held over the ack edge is the old one
          if (i_wb_cyc && i_wb_stb && !o_wb_ack) begin
            bus_st <= ST_ACK;
          end
        end
        ST_ACK: begin
          o_wb_ack <= i_wb_cyc && i_wb_stb;
          bus_st <= ST_IDLE;
          o_wb_dat <= 32'h00000000;
          case (i_wb_adr)
            `DSW_REG_CTRL: begin
              if (i_wb_we && i_wb_cyc && i_wb_stb) begin
                ctrl <= merge_bytes(ctrl, i_wb_dat, i_wb_sel);
              end
              o_wb_dat <= ctrl;
            end
            `DSW_REG_STATUS: begin
              o_wb_dat <= {8'h00, tbl_count, 14'h0000, o_cap_pa, up_cap};
            end
            `DSW_REG_SIZE: begin
              if (i_wb_we && i_wb_cyc && i_wb_stb) begin
                max_size <= i_wb_dat[LEN_W-1:0];
              end
              o_wb_dat <= {{(32-LEN_W){1'b0}}, max_size};
            end
            `DSW_REG_COUNT: begin
              o_wb_dat <= {16'h0000, direct_cnt};
            end
            default: begin
              o_wb_dat <= 32'h00000000;
            end
          endcase
        end
        default: begin
          bus_st <= ST_IDLE;
          o_wb_ack <= 1'b0;
        end
      endcase
    end
  end
endmodule // dsw_switch

// ===== include/dsw_map.vh
`ifndef DSW_MAP_VH
`define DSW_MAP_VH
// Wishbone register byte offsets
`define DSW_REG_CTRL 8'h00
`define DSW_REG_STATUS 8'h04
`define DSW_REG_SIZE 8'h08
`define DSW_REG_COUNT 8'h0c
// Control register fields
`define DSW_CTRL_EN_BIT 0
`define DSW_CTRL_AGG_BIT 1
`define DSW_CTRL_SID_LSB 8
// Reset values
`define DSW_CTRL_RST 32'h00000003
`define DSW_SIZE_RST 16'h0040
// Connection control and header direction field values
`define DSW_CON_TYPE_DIRECT 1'b1
`define DSW_CON_N_OPEN 1'b0
`define DSW_CON_N_CLOSE 1'b1
`define DSW_DIR_UP 1'b0
`define DSW_DIR_DOWN 1'b1
`endif

// ===== core/dsw_cap_table.v
`include "dsw_map.vh"
// Aggregation capability per Switch SID, learned from PRO_ACK sniffing
module dsw_cap_table #(
  parameter SID_W = 8
) (
  input wire i_clk, // Clock
  input wire i_arst_n, // Async reset, active low
  input wire i_pro_valid, // PRO_ACK observed
  input wire [SID_W-1:0] i_pro_sid, // PKT.SID of PRO_ACK
  input wire [SID_W-1:0] i_pro_new_sid, // SID granted to promoted Switch
  input wire i_pro_nad, // PKT.NAD of PRO_ACK
  input wire [SID_W-1:0] i_own_sid, // Own SID
  input wire [SID_W-1:0] i_look_sid, // Lookup SID
  output wire o_look_cap // Lookup: 1 = aggregation allowed
);
  localparam N = 1 << SID_W;
  reg [N-1:0] cap;
  wire learned;
  // Unknown Switches start incapable, the safe side
  assign learned = (i_pro_sid == i_own_sid) ? ~i_pro_nad : cap[i_pro_sid];
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cap <= {N{1'b0}};
    end else if (i_pro_valid) begin
      cap[i_pro_new_sid] <= learned;
    end
  end
  assign o_look_cap = cap[i_look_sid];
endmodule // dsw_cap_table

// ===== core/dsw_direct_table.v
`include "dsw_map.vh"
// Direct switching table: uplink CID -> downlink CID plus NAD
module dsw_direct_table #(
  parameter DEPTH = 8,
  parameter CID_W = 30
) (
  input wire i_clk, // Clock
  input wire i_arst_n, // Async reset, active low
  input wire i_add, // Add entry pulse
  input wire i_del, // Remove entry pulse
  input wire [CID_W-1:0] i_wr_up, // Uplink CID to add/remove
  input wire [CID_W-1:0] i_wr_dn, // Downlink CID to add
  input wire i_wr_nad, // Destination NAD to add
  input wire [CID_W-1:0] i_look_up, // Uplink CID lookup
  output reg o_hit, // Lookup matched
  output reg [CID_W-1:0] o_dn, // Downlink CID of match
  output reg o_nad, // NAD of match
  output wire [7:0] o_count // Entries in use
);
  reg [DEPTH-1:0] vld;
  reg [CID_W-1:0] up_mem [0:DEPTH-1];
  reg [CID_W-1:0] dn_mem [0:DEPTH-1];
  reg [DEPTH-1:0] nad_mem;
  reg [7:0] cnt;
  integer k;
  integer m;
  integer p;
  integer q;
  reg [DEPTH-1:0] wr_match;
  reg [DEPTH-1:0] free_sel;
  reg [DEPTH-1:0] wr_sel;
  reg found;
  always @* begin
    found = 1'b0;
    free_sel = {DEPTH{1'b0}};
    wr_match = {DEPTH{1'b0}};
    o_hit = 1'b0;
    o_dn = {CID_W{1'b0}};
    o_nad = 1'b0;
    for (k = 0; k < DEPTH; k = k + 1) begin
      wr_match[k] = vld[k] && (up_mem[k] == i_wr_up);
      if (!vld[k] && !found) begin
        free_sel[k] = 1'b1;
        found = 1'b1;
      end
      if (vld[k] && up_mem[k] == i_look_up && !o_hit) begin
        o_hit = 1'b1;
        o_dn = dn_mem[k];
        o_nad = nad_mem[k];
      end
    end
    wr_sel = (wr_match != {DEPTH{1'b0}}) ? wr_match : free_sel;
  end
  // Re-adding an existing uplink CID overwrites it; a full table drops adds
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      vld <= {DEPTH{1'b0}};
      nad_mem <= {DEPTH{1'b0}};
    end else begin
      for (m = 0; m < DEPTH; m = m + 1) begin
        if (i_del && wr_match[m]) begin
          vld[m] <= 1'b0;
        end else if (i_add && wr_sel[m]) begin
          vld[m] <= 1'b1;
          nad_mem[m] <= i_wr_nad;
        end
      end
    end
  end
  always @(posedge i_clk) begin
    for (p = 0; p < DEPTH; p = p + 1) begin
      if (i_add && wr_sel[p]) begin
        up_mem[p] <= i_wr_up;
        dn_mem[p] <= i_wr_dn;
      end
    end
  end
  always @* begin
    cnt = 8'h00;
    for (q = 0; q < DEPTH; q = q + 1) begin
      cnt = cnt + {7'h00, vld[q]};
    end
  end
  assign o_count = cnt;
endmodule // dsw_direct_table

// ===== verification/dsw_checker.sv
module dsw_checker #(
  parameter int SID_W = 8, LNID_W = 14, LCID_W = 8, LEN_W = 16
) (
  input wire logic i_clk, i_arst_n, i_wb_we, i_wb_cyc, i_wb_stb, o_wb_ack,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  input wire logic i_pkt_valid, i_pkt_dir, i_pkt_nad, i_reg_rsp_valid, i_reg_cap_pa,
  input wire logic [SID_W-1:0] i_pkt_sid, o_out_sid,
  input wire logic [LNID_W-1:0] i_pkt_lnid, o_out_lnid,
  input wire logic [LCID_W-1:0] i_pkt_lcid, o_out_lcid,
  input wire logic [LEN_W-1:0] i_pkt_len,
  input wire logic o_out_valid, o_out_dir, o_out_nad, o_out_direct, o_out_agg_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [SID_W-1:0] own;
  logic [LEN_W-1:0] size;
  logic agg, up;
  // Shadow of control state, taken where the master sees the write land
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      own <= 8'h00;
      size <= 16'h0040;
      agg <= 1'h1;
      up <= 1'h0;
    end else begin
      if (i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack && i_wb_adr == 8'h00) begin
        if (i_wb_sel[0]) agg <= i_wb_dat[1];
        if (i_wb_sel[1]) own <= i_wb_dat[8 +: SID_W];
      end
      if (i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack && i_wb_adr == 8'h08)
        size <= i_wb_dat[LEN_W-1:0];
      if (i_reg_rsp_valid) up <= i_reg_cap_pa;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  out_cause_a: assert property (o_out_valid |-> $past(i_pkt_valid)) else $error("stray output");
  direct_down_a: assert property (o_out_valid && o_out_direct |-> o_out_dir
    && !$past(i_pkt_dir)) else $error("direct frame not turned down");
  pass_thru_a: assert property (o_out_valid && !o_out_direct |->
    o_out_dir == $past(i_pkt_dir) && o_out_sid == $past(i_pkt_sid)
    && o_out_lnid == $past(i_pkt_lnid) && o_out_lcid == $past(i_pkt_lcid))
    else $error("unmatched frame altered");
  agg_limit_a: assert property (o_out_valid && o_out_agg_ok |-> $past(agg)
    && $past(i_pkt_len) <= $past(size)) else $error("aggregation beyond limit");
  last_level_a: assert property (o_out_valid && o_out_dir && !o_out_direct
    && $past(i_pkt_sid) == $past(own) |-> o_out_agg_ok == (!$past(i_pkt_nad)
    && $past(agg) && $past(i_pkt_len) <= $past(size))) else $error("last level wrong");
  uplink_cap_a: assert property (o_out_valid && !o_out_dir && o_out_agg_ok
    |-> $past(up)) else $error("uplink aggregated without grant");
  direct_nad_a: assert property (o_out_valid && o_out_direct |-> o_out_agg_ok ==
    (!o_out_nad && $past(agg) && $past(i_pkt_len) <= $past(size)))
    else $error("direct aggregation ignores destination");
endmodule // dsw_checker

bind dsw_switch dsw_checker #(.SID_W(SID_W), .LNID_W(LNID_W), .LCID_W(LCID_W),
  .LEN_W(LEN_W)) dsw_checker_inst (.*);

// ===== verification/peer.sv
module peer (
  input wire logic i_clk, // Switch clock
  output logic i_pkt_valid, i_pkt_dir, i_pkt_nad, i_con_valid, i_con_type, i_con_n,
  output logic i_con_d, i_con_dcnad, i_pro_valid, i_reg_rsp_valid, i_reg_cap_pa,
  output logic [7:0] i_pkt_sid, i_pkt_lcid, i_con_dssid, i_con_lcid, i_con_dcsid,
  output logic [7:0] i_con_dclcid, i_pro_new_sid,
  output logic [13:0] i_pkt_lnid, i_con_dclnid,
  output logic [15:0] i_pkt_len
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {i_pkt_valid, i_con_valid, i_pro_valid, i_reg_rsp_valid} = 4'h0;
    {i_pkt_dir, i_pkt_nad, i_con_type, i_con_n, i_con_d, i_con_dcnad, i_reg_cap_pa} = 7'h0;
    {i_pkt_sid, i_pkt_lcid, i_con_dssid, i_con_lcid, i_con_dcsid, i_con_dclcid} = 48'h0;
    {i_pro_new_sid, i_pkt_lnid, i_con_dclnid, i_pkt_len} = 52'h0;
  end
  // Released PKT.SID/LNID/LCID lines flip, so a stale CID never passes for a live one
  task automatic end_frame;
    @(posedge i_clk);
    {i_pkt_valid, i_con_valid, i_pro_valid, i_reg_rsp_valid} <= 4'h0;
    {i_pkt_sid, i_pkt_lnid, i_pkt_lcid} <= ~{i_pkt_sid, i_pkt_lnid, i_pkt_lcid};
    @(posedge i_clk);
  endtask
  task automatic pkt(input logic d, input logic [7:0] s, input logic [13:0] ln,
      input logic [7:0] lc, input logic n, input logic [15:0] len);
    {i_pkt_dir, i_pkt_sid, i_pkt_lnid, i_pkt_lcid, i_pkt_len} <= {d, s, ln, lc, len};
    i_pkt_nad <= n;
    i_pkt_valid <= 1'h1;
    end_frame();
  endtask
  task automatic con(input logic n, d, input logic [7:0] dss, s, lc, ds, dlc,
      input logic dn);
    {i_pkt_sid, i_pkt_lnid, i_con_lcid} <= {s, 14'h1, lc};
    {i_con_type, i_con_n, i_con_d, i_con_dssid} <= {1'h1, n, d, dss};
    {i_con_dcsid, i_con_dclnid, i_con_dclcid, i_con_dcnad} <= {ds, 14'h1, dlc, dn};
    i_pkt_dir <= 1'h1;
    i_con_valid <= 1'h1;
    end_frame();
  endtask
  task automatic pro(input logic [7:0] s, input logic n, input logic [7:0] ns);
    {i_pkt_sid, i_pkt_nad, i_pro_new_sid, i_pro_valid} <= {s, n, ns, 1'h1};
    end_frame();
  endtask
  task automatic rsp(input logic c);
    {i_reg_cap_pa, i_reg_rsp_valid} <= {c, 1'h1};
    end_frame();
  endtask
endmodule // peer

// ===== verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'h0;
  logic i_arst_n = 1'h0;
  logic i_wb_we = 1'h0;
  logic i_wb_cyc = 1'h0;
  logic i_wb_stb = 1'h0;
  logic [3:0] i_wb_sel = 4'hf;
  logic [7:0] i_wb_adr = 8'h00;
  logic [31:0] i_wb_dat = 32'h0;
  logic i_pkt_valid, i_pkt_dir, i_pkt_nad, i_con_valid, i_con_type, i_con_n, i_con_d;
  logic i_con_dcnad, i_pro_valid, i_reg_rsp_valid, i_reg_cap_pa, o_wb_ack, o_cap_pa;
  logic [7:0] i_pkt_sid, i_pkt_lcid, i_con_dssid, i_con_lcid, i_con_dcsid, i_con_dclcid;
  logic [7:0] i_pro_new_sid, o_out_sid, o_out_lcid, s;
  logic [13:0] i_pkt_lnid, i_con_dclnid, o_out_lnid, ln;
  logic [15:0] i_pkt_len, len;
  logic [31:0] o_wb_dat, rd;
  logic o_out_valid, o_out_dir, o_out_nad, o_out_direct, o_out_agg_ok;
  logic [31:0] seed = 32'h0157410b;
  logic [15:0] size = 16'h0040;
  logic up_cap = 1'h0;
  logic agg_en = 1'h1;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int i;
  always #20 i_clk = ~i_clk;
  dsw_switch dsw_switch_inst (.*);
  peer peer_inst (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic agg_exp(input logic cap, input logic [15:0] l);
    return cap && agg_en && l <= size;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic out_chk(input logic d, input logic [7:0] es, input logic [13:0] el,
      input logic [7:0] ec, input logic n, dr, ag);
    chk({o_out_valid, o_out_dir, o_out_sid, o_out_lnid, o_out_lcid, o_out_nad,
      o_out_direct, o_out_agg_ok}, {1'h1, d, es, el, ec, n, dr, ag});
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'h3, w, a, d};
    // Only the bench timeout ends a wait that never sees ack
    do begin
      @(posedge i_clk);
    end while (o_wb_ack !== 1'h1);
    rd = o_wb_dat;
    {i_wb_cyc, i_wb_stb} <= 2'h0;
    @(posedge i_clk);
  endtask
  task automatic dcon(input logic n, d, input logic [7:0] dss, input logic rev);
    if (rev) peer_inst.con(n, d, dss, 8'h03, 8'h42, 8'h01, 8'h21, 1'h1);
    else peer_inst.con(n, d, dss, 8'h01, 8'h21, 8'h03, 8'h42, 1'h0);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      report_and_stop;
    end
  end
  initial begin
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'h1;
    @(posedge i_clk);
    wb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h3);
    wb(1'h0, 8'h08, 32'h0);
    chk(rd, 32'h40);
    wb(1'h1, 8'h10, 32'hffffffff);
    wb(1'h0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    wb(1'h0, 8'h04, 32'h0);
    chk({rd, o_cap_pa}, {32'h2, 1'h1});
    wb(1'h1, 8'h00, 32'h0503);
    dcon(1'h0, 1'h1, 8'h05, 1'h0);
    dcon(1'h0, 1'h1, 8'h05, 1'h1);
    // Closes aimed at another switch or lacking the direct flag must not bite
    dcon(1'h1, 1'h1, 8'h06, 1'h0);
    dcon(1'h1, 1'h0, 8'h05, 1'h0);
    wb(1'h0, 8'h04, 32'h0);
    chk(rd[23:16], 8'h02);
    for (i = 0; i < 2; i++) begin
      len = 16'h0040 + 16'(i);
      peer_inst.pkt(1'h0, 8'h01, 14'h1, 8'h21, 1'h1, len);
      out_chk(1'h1, 8'h03, 14'h1, 8'h42, 1'h0, 1'h1, agg_exp(1'h1, len));
      peer_inst.pkt(1'h0, 8'h03, 14'h1, 8'h42, 1'h0, len);
      out_chk(1'h1, 8'h01, 14'h1, 8'h21, 1'h1, 1'h1, 1'h0);
    end
    wb(1'h0, 8'h0c, 32'h0);
    chk(rd, 32'h4);
    for (i = 0; i < 24; i++) begin
      if (i == 8) begin
        peer_inst.rsp(1'h1);
        up_cap = 1'h1;
      end
      if (i == 16) begin
        wb(1'h1, 8'h08, 32'h20);
        size = 16'h0020;
      end
      seed = lfsr(seed);
      {s, ln, len} = {seed[7:0], 1'h1, seed[20:8], 9'h000, seed[30:24]};
      peer_inst.pkt(1'h0, s, ln, seed[15:8], seed[31], len);
      out_chk(1'h0, s, ln, seed[15:8], seed[31], 1'h0, agg_exp(up_cap, len));
    end
    peer_inst.pro(8'h05, 1'h0, 8'h09);
    peer_inst.pro(8'h09, 1'h1, 8'h0a);
    peer_inst.pro(8'h05, 1'h1, 8'h0b);
    peer_inst.pro(8'h0b, 1'h0, 8'h0c);
    // Unknown switch 0x14 must be taken as incapable
    for (i = 0; i < 7; i++) begin
      s = 8'(56'h0505090a0b0c14 >> (8 * i));
      seed = lfsr(seed);
      peer_inst.pkt(1'h1, s, seed[13:0], seed[21:14], 1'(i == 6), 16'h0010);
      out_chk(1'h1, s, seed[13:0], seed[21:14], 1'(i == 6), 1'h0,
        agg_exp(1'(i > 2 && i < 6), 16'h0010));
    end
    dcon(1'h1, 1'h1, 8'h05, 1'h0);
    peer_inst.pkt(1'h0, 8'h01, 14'h1, 8'h21, 1'h0, 16'h0010);
    out_chk(1'h0, 8'h01, 14'h1, 8'h21, 1'h0, 1'h0, 1'h1);
    wb(1'h1, 8'h00, 32'h0501);
    agg_en = 1'h0;
    peer_inst.pkt(1'h0, 8'h07, 14'h2, 8'h33, 1'h0, 16'h0010);
    out_chk(1'h0, 8'h07, 14'h2, 8'h33, 1'h0, 1'h0, agg_exp(1'h1, 16'h0010));
    chk(o_cap_pa, 1'h0);
    wb(1'h1, 8'h00, 32'h0500);
    peer_inst.pkt(1'h0, 8'h07, 14'h2, 8'h33, 1'h0, 16'h0010);
    chk(o_out_valid, 1'h0);
    report_and_stop;
  end
endmodule // tb
